// ---- design/buck_ctrl_pkg.sv ----
package buck_ctrl_pkg;

  // System clock
  localparam int CLK_NS = 100;

  // Register byte addresses
  localparam logic [7:0] ADR_SEL      = 8'h00;
  localparam logic [7:0] ADR_RES_LO   = 8'h01;
  localparam logic [7:0] ADR_RES_HI   = 8'h02;
  localparam logic [7:0] ADR_EVT      = 8'h03;
  localparam logic [7:0] ADR_MASK     = 8'h04;
  localparam logic [7:0] ADR_CLK      = 8'h05;
  localparam logic [7:0] ADR_FUNC     = 8'h06;
  localparam logic [7:0] ADR_GPIO     = 8'h07;
  localparam logic [7:0] ADR_GPIO_OUT = 8'h08;
  localparam logic [7:0] ADR_MCTRL    = 8'h09;
  localparam logic [7:0] ADR_SCTRL    = 8'h0a;
  localparam logic [7:0] ADR_ILIM     = 8'h0b;
  localparam logic [7:0] ADR_GPIO_IN  = 8'h0c;

  // Bits of top_event_reg and top_event_mask_reg
  localparam int EV_LOAD   = 0;
  localparam int EV_SYNC   = 1;
  localparam int EV_NOSYNC = 2;
  localparam int EV_W      = 3;
  localparam logic [EV_W-1:0] MASK_RST = 3'h7;

  // Master control bits
  localparam int MC_EN  = 0;
  localparam int MC_DIS = 1;

  // Clock-source field values
  localparam logic [1:0] MODE_RC     = 2'h0;
  localparam logic [1:0] MODE_AUTO   = 2'h1;
  localparam logic [1:0] MODE_ACTIVE = 2'h2;

  // Load measurement
  localparam int         PHASES      = 4;
  localparam int         LOAD_W      = 10;
  localparam int         LO_W        = 8;
  localparam logic [1:0] MASTER_PHASE = 2'h0;
  localparam logic [LOAD_W-1:0] LOAD_MAX = 10'h3ff;
  localparam int MEAS_NS     = 4000;
  localparam int MEAS_MAX_NS = 50000;
  localparam int MEAS_CYC    = (MEAS_NS + CLK_NS - 1) / CLK_NS;
  localparam int MEAS_MAX_CYC = MEAS_MAX_NS / CLK_NS;

  // Sync clock detector
  localparam int MISS_NS     = 1800;
  localparam int MISS_CYC    = MISS_NS / CLK_NS;
  localparam int DEB_NS      = 10000;
  localparam int DEB_CYC     = DEB_NS / CLK_NS;
  localparam int CHANGE_NS   = 600000;
  localparam int NS_MHZ_X10  = 10000;
  localparam int ACC_LO_NUM  = 7;
  localparam int ACC_HI_NUM  = 11;
  localparam int BYTE_BITS   = 8;

  typedef logic [LOAD_W-1:0] load_t;

  typedef struct packed {
    logic       rsv;
    logic [4:0] nominalSyncFreq;
    logic [1:0] clkMode;
  } clk_cfg_s;

  typedef struct packed {
    logic [5:0] rsv;
    logic       forceMulti;
    logic       freqSpreadingOn;
  } func_s;

  typedef struct packed {
    logic [1:0] rsv;
    logic [2:0] dirOut;
    logic [2:0] useGpio;
  } gpio_cfg_s;

  typedef struct packed {
    logic [1:0] rsv;
    logic [2:0] openDrain;
    logic [2:0] level;
  } gpio_out_s;

  typedef struct packed {
    logic [1:0] rsv;
    logic [2:0] ctl;
    logic [2:0] outputDischargeEnable;
  } slave_ctrl_s;

  typedef enum logic [3:0] {
    I2C_IDLE, I2C_ADDR, I2C_AACK_W, I2C_AACK_R, I2C_PTR, I2C_PACK,
    I2C_WDATA, I2C_WACK, I2C_RDATA, I2C_RACK
  } i2c_st_e;

endpackage

// ---- design/buck_clock_sync_and_load_monitor.sv ----
`timescale 1ns/1ns
// How it works
// - Writing the phase-select register starts a new load measurement.
// - A measurement finishes within fifty microseconds of its start.
// - Finished measurement sets a done flag; a mask bit gates its interrupt.
// - Ten-bit result: low eight bits in one register, top two in another.
// - One result count is 20 mA; full code equals full-scale current.
// - Master selected gives summed current of all phases; slave gives its own.
// - Merged regulator takes its settings only from master control registers.
// - Slave control ignored, except discharge enable and current-limit flags.
// - Four phases start a quarter internal period apart; on the sync clock, phases offset past the next sync edge never start.
// - Frequency spreading acts on all phases only with internal RC selected.
// - Clock source and clock-change interrupts follow mode and presence; maskable.
// - Five-bit field sets expected sync clock, one to twenty-four MHz.
// - Sync clock valid only within minus 30 to plus 10 percent.
// - Missing-clock interrupt on config load in mode 1, activation in mode 2.
// - Each enable pin can be a GPIO with direction and drive type.
// - Force bit forces multiphase and fixed-frequency PWM together.
// - Mode 0 detector off, 1 standby and active, 2 active only.
// - Switch to sync clock about 600 us after valid detection.
// - Missing clock seen within 1.8 us; new clock debounced up to 10 us.
module buck_clock_sync_and_load_monitor
  import buck_ctrl_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR   = 7'h2a,  // Arbitrary bus address
  parameter int         SW_PERIOD  = 40,
  parameter int         CHANGE_CYC = CHANGE_NS / CLK_NS
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  sclIn,
  input  wire logic                  sdaIn,
  output logic                       sdaOut,
  output logic                       sdaOe_n,
  input  wire logic [2:0]            enIn,
  output logic [2:0]                 enOut,
  output logic [2:0]                 enOe_n,
  input  wire logic                  syncClockInput,
  input  wire logic                  devActive,
  input  wire logic                  configDone,
  input  wire load_t [PHASES-1:0]    phaseCurrent,
  input  wire logic [PHASES-1:0]     phaseCurrentLimit,
  output logic                       irq,
  output logic                       useExtClock,
  output logic                       freqSpreadActive,
  output logic [PHASES-1:0]          phaseStart,
  output logic                       regEnable,
  output logic [PHASES-1:0]          dischargeEnable,
  output logic                       forceMultiphase,
  output logic                       forcePwm,
  output logic [2:0]                 enPinLevel
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic freqOk(input logic [11:0] per, input logic [4:0] f);
    int unsigned p;
    p = int'(per) * CLK_NS * int'(f);
    return (p * ACC_LO_NUM <= NS_MHZ_X10) && (p * ACC_HI_NUM >= NS_MHZ_X10);
  endfunction

  function automatic load_t sumSat(input load_t [PHASES-1:0] c);
    logic [LOAD_W+1:0] s;
    s = '0;
    for (int i = 0; i < PHASES; i++) begin
      s = s + {2'h0, c[i]};
    end
    return (s > {2'h0, LOAD_MAX}) ? LOAD_MAX : s[LOAD_W-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stages feed only the second stages

  logic sclM, sclS, sclD, sdaM, sdaS, sdaD, syM, syS, syD;
  logic [2:0] enM, enS;
  load_t [PHASES-1:0] curM, curS, curQ, curV;

  always_ff @(posedge clk) begin
    {sclM, sclS, sclD} <= {sclIn, sclM, sclS};
    {sdaM, sdaS, sdaD} <= {sdaIn, sdaM, sdaS};
    {syM, syS, syD}    <= {syncClockInput, syM, syS};
    {enM, enS}         <= {enIn, enM};
    {curM, curS}       <= {phaseCurrent, curM};
    curQ               <= curS;
    curV               <= (curS == curQ) ? curS : curV;  // Skewed bus words never used
  end

  // Bus conditions
  wire startC = sclS & sdaD & ~sdaS;
  wire stopC  = sclS & ~sdaD & sdaS;
  wire sclRise = sclS & ~sclD;
  wire sclFall = ~sclS & sclD;
  wire extEdge = syS & ~syD;

  ////////////////////////////////////////////////////////////////////////////
  // Serial register port; standard and fast mode only at this clock rate

  i2c_st_e    st;
  logic [3:0] bitCnt;
  logic [7:0] shft, ptr, rdData;
  logic       drvLow;
  wire rxState = (st == I2C_ADDR) | (st == I2C_PTR) | (st == I2C_WDATA);
  wire byteDone = bitCnt == 4'(BYTE_BITS);
  wire wrStb = sclFall & (st == I2C_WDATA) & byteDone;
  wire [7:0] wrData = shft;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= I2C_IDLE;
      bitCnt <= '0;
      shft <= '0;
      ptr <= '0;
      drvLow <= 1'b0;
    end else if (startC) begin
      st <= I2C_ADDR;
      bitCnt <= '0;
      drvLow <= 1'b0;
    end else if (stopC) begin
      st <= I2C_IDLE;
      drvLow <= 1'b0;
    end else if (sclRise && rxState) begin
      shft <= {shft[6:0], sdaS};
      bitCnt <= bitCnt + 4'h1;
    end else if (sclRise && st == I2C_RACK && sdaS) begin
      st <= I2C_IDLE;  // Master NACK ends the read
    end else if (sclFall) begin
      unique case (st)
        I2C_ADDR: if (byteDone) begin
          drvLow <= shft[7:1] == DEV_ADDR;
          st <= (shft[7:1] != DEV_ADDR) ? I2C_IDLE : shft[0] ? I2C_AACK_R : I2C_AACK_W;
        end
        I2C_PTR: if (byteDone) begin
          ptr <= shft;
          drvLow <= 1'b1;
          st <= I2C_PACK;
        end
        I2C_WDATA: if (byteDone) begin
          ptr <= ptr + 8'h01;
          drvLow <= 1'b1;
          st <= I2C_WACK;
        end
        I2C_AACK_W, I2C_PACK, I2C_WACK: begin
          drvLow <= 1'b0;
          bitCnt <= '0;
          st <= (st == I2C_AACK_W) ? I2C_PTR : I2C_WDATA;
        end
        I2C_AACK_R, I2C_RACK: begin
          shft <= rdData;
          drvLow <= ~rdData[7];
          bitCnt <= 4'h1;
          ptr <= ptr + 8'h01;
          st <= I2C_RDATA;
        end
        I2C_RDATA: if (byteDone) begin
          drvLow <= 1'b0;
          st <= I2C_RACK;
        end else begin
          drvLow <= ~shft[6];
          shft <= {shft[6:0], 1'b0};
          bitCnt <= bitCnt + 4'h1;
        end
        I2C_IDLE: ;
        default: st <= I2C_IDLE;
      endcase
    end
  end

  // Open-drain data line
  assign sdaOut = 1'b0;
  assign sdaOe_n = ~drvLow;

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [1:0]        selPhase;
  load_t             result;
  logic [EV_W-1:0]   evt, mask;
  clk_cfg_s          clkCfg;
  func_s             func;
  gpio_cfg_s         gpioCfg;
  gpio_out_s         gpioOut;
  logic [1:0]        masterCtrl;
  slave_ctrl_s       slaveCtrl;
  logic [PHASES-1:0] ilimFlags;
  logic              measBusy, syncPresent, syncEv, noSyncEv;
  logic [5:0]        measCnt;

  wire selWrite = wrStb & (ptr == ADR_SEL);
  wire measDone = measBusy & (measCnt == 6'(MEAS_CYC - 1)) & ~selWrite;
  wire [EV_W-1:0] evtClr = (wrStb && ptr == ADR_EVT) ? wrData[EV_W-1:0] : '0;
  wire [EV_W-1:0] evtSet = {noSyncEv, syncEv, measDone};
  wire [PHASES-1:0] ilimClr = (wrStb && ptr == ADR_ILIM) ? wrData[PHASES-1:0] : '0;
  wire [EV_W-1:0] next_evt = (evt & ~evtClr) | evtSet;  // Set wins over clear
  wire load_t measValue = (selPhase == MASTER_PHASE) ? sumSat(curV) : curV[selPhase];

  // Read mux
  always_comb begin
    unique case (ptr)
      ADR_SEL:      rdData = {6'h00, selPhase};
      ADR_RES_LO:   rdData = result[LO_W-1:0];
      ADR_RES_HI:   rdData = {6'h00, result[LOAD_W-1:LO_W]};
      ADR_EVT:      rdData = {5'h00, evt};
      ADR_MASK:     rdData = {5'h00, mask};
      ADR_CLK:      rdData = clkCfg;
      ADR_FUNC:     rdData = func;
      ADR_GPIO:     rdData = gpioCfg;
      ADR_GPIO_OUT: rdData = gpioOut;
      ADR_MCTRL:    rdData = {6'h00, masterCtrl};
      ADR_SCTRL:    rdData = slaveCtrl;
      ADR_ILIM:     rdData = {4'h0, ilimFlags};
      ADR_GPIO_IN:  rdData = {5'h00, enS};
      default:      rdData = 8'h00;
    endcase
  end

  // Software writes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask <= MASK_RST;
      clkCfg <= '0;
      func <= '0;
      gpioCfg <= '0;
      gpioOut <= '0;
      masterCtrl <= '0;
      slaveCtrl <= '0;
    end else if (wrStb) begin
      unique case (ptr)
        ADR_MASK:     mask <= wrData[EV_W-1:0];
        ADR_CLK:      clkCfg <= wrData;
        ADR_FUNC:     func <= {6'h00, wrData[1:0]};
        ADR_GPIO:     gpioCfg <= {2'h0, wrData[5:0]};
        ADR_GPIO_OUT: gpioOut <= {2'h0, wrData[5:0]};
        ADR_MCTRL:    masterCtrl <= wrData[1:0];
        ADR_SCTRL:    slaveCtrl <= {2'h0, wrData[5:0]};
        default: ;
      endcase
    end
  end

  // Sticky flags and interrupt line
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      evt <= '0;
      ilimFlags <= '0;
      irq <= 1'b0;
    end else begin
      evt <= next_evt;
      ilimFlags <= (ilimFlags & ~ilimClr) | phaseCurrentLimit;
      irq <= |(next_evt & ~mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Load measurement; a rewrite restarts the sequence

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      measBusy <= 1'b0;
      measCnt <= '0;
      selPhase <= MASTER_PHASE;
      result <= '0;
    end else if (selWrite) begin
      measBusy <= 1'b1;
      measCnt <= '0;
      selPhase <= wrData[1:0];
    end else if (measDone) begin
      measBusy <= 1'b0;
      result <= measValue;
    end else if (measBusy) begin
      measCnt <= measCnt + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sync clock detector; frequencies above the sample rate are not measurable

  logic [11:0] perCnt;
  logic [7:0]  debCnt;
  logic [15:0] chgCnt;
  logic        goodRun, cfgD, actD;
  wire detOn = (clkCfg.clkMode == MODE_AUTO) |
               ((clkCfg.clkMode == MODE_ACTIVE) & devActive);
  wire goodEdge = extEdge & freqOk(perCnt, clkCfg.nominalSyncFreq);
  wire lost = (perCnt == 12'(MISS_CYC)) | (extEdge & ~goodEdge);
  wire next_present = detOn & (syncPresent ? ~lost : debCnt == 8'(DEB_CYC));

  always_ff @(posedge clk) begin
    if (sys_rst || !detOn) begin
      perCnt <= '0;
      goodRun <= 1'b0;
      debCnt <= '0;
    end else begin
      perCnt <= extEdge ? 12'h001 : perCnt + {11'h000, ~&perCnt};
      goodRun <= goodEdge | (goodRun & ~lost);
      debCnt <= (lost || !goodRun) ? 8'h00 : debCnt + {7'h00, debCnt != 8'(DEB_CYC)};
    end
  end

  // Presence, changeover and events
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      syncPresent <= 1'b0;
      useExtClock <= 1'b0;
      chgCnt <= '0;
      cfgD <= 1'b0;
      actD <= 1'b0;
      syncEv <= 1'b0;
      noSyncEv <= 1'b0;
    end else begin
      syncPresent <= next_present;
      syncEv <= detOn & (next_present != syncPresent);
      chgCnt <= (syncPresent && !useExtClock) ? chgCnt + 16'h0001 : '0;
      if (!syncPresent)
        useExtClock <= 1'b0;
      else if (chgCnt == 16'(CHANGE_CYC))
        useExtClock <= 1'b1;
      cfgD <= configDone;
      actD <= devActive;
      noSyncEv <= ~syncPresent &
        (((clkCfg.clkMode == MODE_AUTO) & configDone & ~cfgD) |
         ((clkCfg.clkMode == MODE_ACTIVE) & devActive & ~actD));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase interleave; spreading dithers the internal period

  logic [7:0] phCnt;
  logic [1:0] dith;
  wire [7:0] period = 8'(SW_PERIOD) + (freqSpreadActive ? {6'h00, dith} : 8'h00);
  wire wrap = (phCnt >= period - 8'h01) | (useExtClock & extEdge);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phCnt <= '0;
      dith <= '0;
      phaseStart <= '0;
      freqSpreadActive <= 1'b0;
    end else begin
      phCnt <= wrap ? 8'h00 : phCnt + 8'h01;
      dith <= dith + {1'b0, wrap};
      freqSpreadActive <= func.freqSpreadingOn & (clkCfg.clkMode == MODE_RC);
      for (int i = 0; i < PHASES; i++) begin
        phaseStart[i] <= phCnt == 8'((i * int'(period)) / PHASES);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Regulator controls and enable-pin GPIOs

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regEnable <= 1'b0;
      dischargeEnable <= '0;
      forceMultiphase <= 1'b0;
      forcePwm <= 1'b0;
      enOut <= '0;
      enOe_n <= '1;
      enPinLevel <= '0;
    end else begin
      regEnable <= masterCtrl[MC_EN];
      dischargeEnable <= {slaveCtrl.outputDischargeEnable, masterCtrl[MC_DIS]};
      forceMultiphase <= func.forceMulti;
      forcePwm <= func.forceMulti;
      enOut <= gpioOut.level & ~gpioOut.openDrain;
      enOe_n <= ~(gpioCfg.useGpio & gpioCfg.dirOut &
                  (~gpioOut.openDrain | ~gpioOut.level));
      enPinLevel <= enS & ~gpioCfg.useGpio;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  localparam int MEAS_LIM = MEAS_MAX_CYC;  // Longest allowed sequence
  sequence seqLaunch;
    selWrite ##1 measBusy;
  endsequence

  a_meas_launch: assert property (@(posedge clk) disable iff (sys_rst)
    selWrite |-> seqLaunch) else $error("measurement not launched");
  a_meas_bound: assert property (@(posedge clk) disable iff (sys_rst)
    seqLaunch |-> ##[0:MEAS_LIM] !measBusy) else $error("measurement too long");
  a_done_flag: assert property (@(posedge clk) disable iff (sys_rst)
    measDone |=> evt[EV_LOAD] ##1 (irq || mask[EV_LOAD])) else $error("done flag missing");
  a_result_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(measDone) |-> $stable(result)) else $error("result changed early");
  a_slave_only: assert property (@(posedge clk) disable iff (sys_rst)
    measDone && selPhase != MASTER_PHASE |=> result == $past(curV[selPhase]))
    else $error("slave result wrong");
  a_high_split: assert property (@(posedge clk) disable iff (sys_rst)
    ptr == ADR_RES_HI |-> rdData == {6'h00, result[LOAD_W-1:LO_W]}) else $error("high split");
  a_spread_rc: assert property (@(posedge clk) disable iff (sys_rst)
    freqSpreadActive |-> $past(clkCfg.clkMode) == MODE_RC) else $error("spread off RC");
  a_ext_after: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(useExtClock) |-> $past(syncPresent) && $past(chgCnt) == 16'(CHANGE_CYC))
    else $error("early changeover");
  a_miss_drop: assert property (@(posedge clk) disable iff (sys_rst)
    syncPresent && perCnt == 12'(MISS_CYC) |=> !syncPresent ##1 !useExtClock)
    else $error("missing clock not seen");

endmodule

// ---- sim/bus_host_model.sv ----
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Host on the serial register bus plus the external sync clock source
module bus_host_model
  import buck_ctrl_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2a  // Arbitrary bus address
) (
  input  wire logic clk,
  input  wire logic sdaOut,
  input  wire logic sdaOe_n,
  input  wire logic syncOn,
  output logic      sclIn,
  output logic      sdaIn,
  output logic      syncClockInput
);
  logic sdaDrv;
  logic nak;

  // Pull-up level unless someone pulls the data line low
  assign sdaIn = sdaDrv & (sdaOe_n | sdaOut);

  initial begin
    sclIn = 1'b1;
    sdaDrv = 1'b1;
    nak = 1'b0;
    syncClockInput = 1'b0;
  end

  // 1 MHz source; stands low while off so no stale edge reaches the detector
  always begin
    #500;
    syncClockInput = syncOn ? ~syncClockInput : 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One bit: data set while the clock is low, sampled mid high phase
  task automatic bitx(input logic b, output logic r);
    @(posedge clk) sdaDrv <= b;
    hold(4);
    sclIn <= 1'b1;
    hold(4);
    r = sdaIn;
    hold(4);
    sclIn <= 1'b0;
  endtask

  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
      q = {q[6:0], r};
    end
  endtask

  // A missing acknowledge is remembered for the bench to judge
  task automatic sendb(input logic [7:0] d);
    logic [7:0] q;
    logic       a;
    xfer(d, q);
    bitx(1'b1, a);
    nak = nak | a;
  endtask

  task automatic start;
    @(posedge clk) sdaDrv <= 1'b1;
    hold(4);
    sclIn <= 1'b1;
    hold(4);
    sdaDrv <= 1'b0;
    hold(4);
    sclIn <= 1'b0;
  endtask

  task automatic stop;
    @(posedge clk) sdaDrv <= 1'b0;
    hold(4);
    sclIn <= 1'b1;
    hold(4);
    sdaDrv <= 1'b1;
    hold(8);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start;
    sendb({DEV_ADDR, 1'b0});
    sendb(a);
    sendb(d);
    stop;
  endtask

  // Pointer set, repeated start, one byte read, then not acknowledged
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    logic n;
    start;
    sendb({DEV_ADDR, 1'b0});
    sendb(a);
    start;
    sendb({DEV_ADDR, 1'b1});
    xfer(8'hff, q);
    bitx(1'b1, n);
    stop;
  endtask
endmodule

// ---- sim/tb_buck_clock_sync_and_load_monitor.sv ----
`timescale 1ns/1ns
module tb_buck_clock_sync_and_load_monitor;
  import buck_ctrl_pkg::*;
  localparam int SWP = 40;
  localparam int CHG = 50;  // Short changeover keeps the run brief
  logic               clk;
  logic               sys_rst;
  logic               syncOn;
  logic               devActive;
  logic               configDone;
  logic               sclIn;
  logic               sdaIn;
  logic               sdaOut;
  logic               sdaOe_n;
  logic               syncClockInput;
  logic               irq;
  logic               useExtClock;
  logic               freqSpreadActive;
  logic               regEnable;
  logic               forceMultiphase;
  logic               forcePwm;
  logic [2:0]         enIn;
  logic [2:0]         enOut;
  logic [2:0]         enOe_n;
  logic [2:0]         enPinLevel;
  load_t [PHASES-1:0] phaseCurrent;
  logic [PHASES-1:0]  phaseCurrentLimit;
  logic [PHASES-1:0]  phaseStart;
  logic [PHASES-1:0]  dischargeEnable;
  logic [7:0]         q;
  int                 nMismatch = 0;
  int                 compares = 0;

  buck_clock_sync_and_load_monitor #(.SW_PERIOD(SWP), .CHANGE_CYC(CHG))
    i_buck_clock_sync_and_load_monitor (.clk(clk), .sys_rst(sys_rst), .sclIn(sclIn),
    .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .enIn(enIn), .enOut(enOut),
    .enOe_n(enOe_n), .syncClockInput(syncClockInput), .devActive(devActive),
    .configDone(configDone), .phaseCurrent(phaseCurrent),
    .phaseCurrentLimit(phaseCurrentLimit), .irq(irq), .useExtClock(useExtClock),
    .freqSpreadActive(freqSpreadActive), .phaseStart(phaseStart),
    .regEnable(regEnable), .dischargeEnable(dischargeEnable),
    .forceMultiphase(forceMultiphase), .forcePwm(forcePwm), .enPinLevel(enPinLevel));
  bus_host_model i_bus_host_model (.clk(clk), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n),
    .syncOn(syncOn), .sclIn(sclIn), .sdaIn(sdaIn), .syncClockInput(syncClockInput));

  initial begin
    clk = 1'b0;
    forever #(CLK_NS / 2) clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      nMismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    i_bus_host_model.rd(a, q);
    check(q, e);
  endtask

  task automatic closeOut;
    if (nMismatch == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tReset;
    check(sdaOe_n, 1'b1);
    check(enOe_n, 3'h7);
    check(irq, 1'b0);
    rdChk(ADR_MASK, {5'h0, MASK_RST});
    rdChk(8'h20, 8'h00);
  endtask

  // Masked slave measurement, then unmasked saturating master sum
  task automatic tLoad;
    @(posedge clk) phaseCurrent <= {10'h200, 10'h200, 10'h155, 10'h200};
    i_bus_host_model.wr(ADR_SEL, 8'h01);
    repeat (MEAS_MAX_CYC - 40) @(posedge clk);
    check(irq, 1'b0);
    rdChk(ADR_RES_LO, 8'h55);
    rdChk(ADR_RES_HI, 8'h01);
    rdChk(ADR_EVT, 8'h01);
    i_bus_host_model.wr(ADR_EVT, 8'h01);
    i_bus_host_model.wr(ADR_MASK, 8'h06);
    i_bus_host_model.wr(ADR_SEL, 8'h00);
    for (int k = 0; k < MEAS_MAX_CYC - 40 && irq !== 1'b1; k++) @(negedge clk);
    check(irq, 1'b1);
    rdChk(ADR_RES_LO, 8'hff);
    rdChk(ADR_RES_HI, 8'h03);
    i_bus_host_model.wr(ADR_EVT, 8'h01);
    check(irq, 1'b0);
  endtask

  // Starts of the four phases fall a quarter period apart
  task automatic tPhase;
    for (int k = 0; k < 2 * SWP && phaseStart[0] !== 1'b1; k++) @(negedge clk);
    check(phaseStart, 4'h1);
    for (int p = 1; p < PHASES; p++) begin
      repeat (SWP / PHASES) @(negedge clk);
      check(phaseStart, 16'h1 << p);
    end
  endtask

  task automatic tCtrl;
    @(posedge clk) enIn <= 3'b100;
    i_bus_host_model.wr(ADR_SCTRL, 8'h3d);
    check(regEnable, 1'b0);
    i_bus_host_model.wr(ADR_MCTRL, 8'h01);
    check(regEnable, 1'b1);
    check(dischargeEnable, 4'b1010);
    @(posedge clk) phaseCurrentLimit <= 4'h4;
    @(posedge clk) phaseCurrentLimit <= 4'h0;
    rdChk(ADR_ILIM, 8'h04);
    i_bus_host_model.wr(ADR_ILIM, 8'h04);
    rdChk(ADR_ILIM, 8'h00);
    i_bus_host_model.wr(ADR_FUNC, 8'h02);
    check({forceMultiphase, forcePwm}, 2'b11);
    check(enPinLevel, 3'h4);
    i_bus_host_model.wr(ADR_GPIO, 8'h1f);
    i_bus_host_model.wr(ADR_GPIO_OUT, 8'h17);
    check({enOut, enOe_n}, 6'h2e);
    check(enPinLevel, 3'h0);
    rdChk(ADR_GPIO_IN, 8'h04);
  endtask

  task automatic tSync;
    i_bus_host_model.wr(ADR_MASK, 8'h05);
    i_bus_host_model.wr(ADR_CLK, 8'h09);
    @(posedge clk) syncOn <= 1'b1;
    repeat (400) @(posedge clk);
    check(useExtClock, 1'b0);
    i_bus_host_model.wr(ADR_CLK, 8'h05);
    for (int k = 0; k < 400 && useExtClock !== 1'b1; k++) @(negedge clk);
    check({useExtClock, irq}, 2'b11);
    i_bus_host_model.wr(ADR_FUNC, 8'h01);
    check(freqSpreadActive, 1'b0);
    i_bus_host_model.wr(ADR_EVT, 8'h07);
    @(posedge clk) syncOn <= 1'b0;
    for (int k = 0; k < 40 && useExtClock !== 1'b0; k++) @(negedge clk);
    repeat (3) @(negedge clk);
    check({useExtClock, irq}, 2'b01);
    i_bus_host_model.wr(ADR_CLK, 8'h04);
    check(freqSpreadActive, 1'b1);
    i_bus_host_model.wr(ADR_CLK, 8'h06);
    i_bus_host_model.wr(ADR_EVT, 8'h07);
    @(posedge clk) configDone <= 1'b1;
    rdChk(ADR_EVT, 8'h00);
    @(posedge clk) devActive <= 1'b1;
    rdChk(ADR_EVT, 8'h04);
    @(posedge clk) configDone <= 1'b0;
    devActive <= 1'b0;
    i_bus_host_model.wr(ADR_CLK, 8'h05);
    i_bus_host_model.wr(ADR_EVT, 8'h07);
    @(posedge clk) configDone <= 1'b1;
    rdChk(ADR_EVT, 8'h04);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    syncOn = 1'b0;
    devActive = 1'b0;
    configDone = 1'b0;
    enIn = 3'h0;
    phaseCurrent = '0;
    phaseCurrentLimit = '0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    tReset;
    tLoad;
    tPhase;
    tCtrl;
    tSync;
    check(i_bus_host_model.nak, 1'b0);
    closeOut;
  end

  // Watchdog, well beyond the expected length of the run
  initial begin
    #(90000 * CLK_NS);
    nMismatch++;
    closeOut;
  end
endmodule
